// >>> ifd_pkg.sv
// Constants, encodings and carrier types for the instruction format decoder
`default_nettype none
package ifd_pkg;
  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned FILE_W  = 8;
  localparam int unsigned PERI_W  = 5;
  localparam int unsigned BITN_W  = 3;
  localparam int unsigned LIT8_W  = 8;
  localparam int unsigned LIT13_W = 13;
  localparam int unsigned OP5_W   = 5;
  localparam int unsigned OP3_W   = 3;
  localparam int unsigned PC_W    = 16;
  localparam int unsigned PM_W    = 3;
  localparam int unsigned PHASE_W = 2;

  // ----------------------------------------------------------------------
  // Class prefixes in the top bits of the word
  // ----------------------------------------------------------------------
  localparam logic [1:0] PFX_BYTE  = 2'h0;
  localparam logic [1:0] PFX_BIT   = 2'h2;
  localparam logic [2:0] PFX_LIT   = 3'h2;
  localparam logic [2:0] PFX_PMOV  = 3'h3;
  localparam logic [2:0] PFX_GOTO  = 3'h6;
  localparam logic [2:0] PFX_CALL  = 3'h7;

  // ----------------------------------------------------------------------
  // Opcode tables (one bit per opcode value) and the top opcode bits of a table code
  // ----------------------------------------------------------------------
  localparam logic [31:0] BYTE_VALID = 32'h00ff_fffc;
  localparam logic [31:0] BYTE_SDEST = 32'h0000_000c;
  localparam logic [31:0] BYTE_SKIP  = 32'h00f0_0000;
  localparam logic [1:0]  TBL_TOP    = 2'h3;
  localparam logic [31:0] LIT_VALID  = 32'h000f_ffff;
  localparam logic [31:0] LIT_PCCHG  = 32'h0000_000f;
  localparam logic [7:0]  BIT_VALID  = 8'h1f;
  localparam logic [7:0]  BIT_SKIP   = 8'h0c;
  localparam logic [7:0]  BIT_WRITE  = 8'h13;

  // Table operation kinds (op bits [2:1] of a table code)
  localparam logic [1:0] TBL_PM_RD  = 2'h0;
  localparam logic [1:0] TBL_PM_WR  = 2'h1;

  // ----------------------------------------------------------------------
  // Timing and protection
  // ----------------------------------------------------------------------
  localparam int unsigned   OSC_PER_CYCLE = 4;
  localparam logic [1:0]    PHASE_LAST    = 2'(OSC_PER_CYCLE - 1);
  localparam logic [1:0]    PHASE_FIRST   = 2'h0;
  localparam logic [2:0]    PM_PROTECTED  = 3'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    IFD_CLS_NONE = 4'h1,
    IFD_CLS_BYTE = 4'h2,
    IFD_CLS_BIT  = 4'h4,
    IFD_CLS_LIT  = 4'h8
  } ifd_class_e;

  typedef enum logic [1:0] {
    IFD_ST_EXEC = 2'h1,
    IFD_ST_NOP  = 2'h2
  } ifd_state_e;

  typedef struct packed {
    logic                 valid;
    logic                 illegal;
    ifd_class_e           cls;
    logic [OP5_W-1:0]     opcode;
    logic [FILE_W-1:0]    file_addr;
    logic [PERI_W-1:0]    periph_addr;
    logic [BITN_W-1:0]    bit_num;
    logic [LIT8_W-1:0]    lit8;
    logic [LIT13_W-1:0]   lit13;
    logic                 lit_is_13;
    logic                 wr_working;
    logic                 wr_file;
    logic                 skip_test;
    logic                 pc_change;
    logic                 tbl_op;
    logic                 tbl_pm_rd;
    logic                 tbl_pm_wr;
    logic                 tbl_inc;
    logic                 tbl_hi;
    logic                 tbl_blocked;
  } ifd_dec_s;

  localparam ifd_dec_s DEC_RESET = '{cls: IFD_CLS_NONE, default: '0};
endpackage : ifd_pkg
`default_nettype wire

// >>> ifd_top.sv
// Instruction format decoder with cycle timing and code-protection gate
//
// Behaviour
// - Accept one 16-bit word per instruction
// - Recognise exactly 58 instructions, flag others
// - Classify byte, bit or literal/control
// - Byte ops: file field selects register
// - Destination bit: 0 working, 1 file
// - Bit ops: bit number plus file field
// - Literal ops carry 8 or 13 bits
// - Default one instruction cycle
// - True test or PC change: two cycles
// - Table read/write: two cycles, second no-op
// - Instruction cycle is four oscillator periods
// - Protection mode bits 000 means protected
// - Protected: internal code may access program memory
// - Protected: external code blocked from table access
// - Unprotected: program memory readable for verify
// - Alternate destination: 0 both, 1 file only
// - Pointer bit: 0 hold, 1 increment
// - Byte select: 0 low latch, 1 high
// - Peripheral field 00h-1Fh, file 00h-FFh
`timescale 1ns/1ps
`default_nettype none
module ifd_top (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Fetch side
  input  wire logic [ifd_pkg::WORD_W-1:0]  instr_word,
  input  wire logic [ifd_pkg::PC_W-1:0]    instr_pc,
  // Datapath feedback
  input  wire logic                        cond_true,
  // Configuration
  input  wire logic [ifd_pkg::PM_W-1:0]    protection_mode_bits,
  input  wire logic [ifd_pkg::PC_W-1:0]    int_mem_last,
  // Timing
  output logic [ifd_pkg::PHASE_W-1:0]      osc_phase,
  output logic                             cycle_start,
  output logic                             nop_slot,
  // Decoded controls
  output ifd_pkg::ifd_dec_s                dec,
  // Protection status
  output logic                             code_protected,
  output logic                             verify_read_en
);

  // ----------------------------------------------------------------------
  // Oscillator phase counter
  // ----------------------------------------------------------------------
  logic [ifd_pkg::PHASE_W-1:0] phase;
  logic [ifd_pkg::PHASE_W-1:0] next_phase;
  logic                        cycle_end;
  logic                        next_cycle_start;

  always_comb begin
    cycle_end        = (phase == ifd_pkg::PHASE_LAST);
    next_phase       = cycle_end ? ifd_pkg::PHASE_FIRST : phase + 2'h1;
    next_cycle_start = cycle_end;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase       <= ifd_pkg::PHASE_FIRST;
      osc_phase   <= ifd_pkg::PHASE_FIRST;
      cycle_start <= 1'b0;
    end else begin
      phase       <= next_phase;
      osc_phase   <= next_phase;
      cycle_start <= next_cycle_start;
    end
  end

  // ----------------------------------------------------------------------
  // Protection mode
  // ----------------------------------------------------------------------
  logic prot_now;
  logic pc_internal;
  logic next_code_protected;
  logic next_verify_read_en;

  always_comb begin
    prot_now            = (protection_mode_bits == ifd_pkg::PM_PROTECTED);
    pc_internal         = (instr_pc <= int_mem_last);
    next_code_protected = prot_now;
    next_verify_read_en = !prot_now;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      code_protected <= 1'b1;
      verify_read_en <= 1'b0;
    end else begin
      code_protected <= next_code_protected;
      verify_read_en <= next_verify_read_en;
    end
  end

  // ----------------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------------
  ifd_pkg::ifd_dec_s        word_dec;
  logic [ifd_pkg::OP5_W-1:0] op5;
  logic [ifd_pkg::OP3_W-1:0] op3;
  logic                      is_tbl;

  always_comb begin
    word_dec             = ifd_pkg::DEC_RESET;
    op5                  = instr_word[13:9];
    op3                  = instr_word[13:11];
    is_tbl               = (op5[4:3] == ifd_pkg::TBL_TOP);
    word_dec.valid       = 1'b1;
    word_dec.file_addr   = instr_word[7:0];
    word_dec.lit8        = instr_word[7:0];
    if (instr_word[15:14] == ifd_pkg::PFX_BYTE) begin
      word_dec.cls    = ifd_pkg::IFD_CLS_BYTE;
      word_dec.opcode = op5;
      if (is_tbl) begin
        word_dec.tbl_op    = 1'b1;
        word_dec.tbl_hi    = op5[0];
        word_dec.tbl_inc   = instr_word[8];
        word_dec.tbl_pm_rd = (op5[2:1] == ifd_pkg::TBL_PM_RD);
        word_dec.tbl_pm_wr = (op5[2:1] == ifd_pkg::TBL_PM_WR);
        word_dec.wr_file   = (op5[2:1] == ifd_pkg::TBL_PM_RD) ||
                             (op5[2:1] != ifd_pkg::TBL_PM_WR && !op5[1] == 1'b0 && op5[2]);
      end else if (ifd_pkg::BYTE_VALID[op5]) begin
        if (ifd_pkg::BYTE_SDEST[op5]) begin
          word_dec.wr_file    = 1'b1;
          word_dec.wr_working = !instr_word[8];
        end else begin
          word_dec.wr_file    = instr_word[8];
          word_dec.wr_working = !instr_word[8];
        end
        word_dec.skip_test = ifd_pkg::BYTE_SKIP[op5];
      end else begin
        word_dec.illegal = 1'b1;
      end
    end else if (instr_word[15:14] == ifd_pkg::PFX_BIT) begin
      word_dec.cls     = ifd_pkg::IFD_CLS_BIT;
      word_dec.opcode  = {2'h0, op3};
      word_dec.bit_num = instr_word[10:8];
      if (ifd_pkg::BIT_VALID[op3]) begin
        word_dec.skip_test = ifd_pkg::BIT_SKIP[op3];
        word_dec.wr_file   = ifd_pkg::BIT_WRITE[op3];
      end else begin
        word_dec.illegal = 1'b1;
      end
    end else if (instr_word[15:13] == ifd_pkg::PFX_GOTO ||
                 instr_word[15:13] == ifd_pkg::PFX_CALL) begin
      word_dec.cls       = ifd_pkg::IFD_CLS_LIT;
      word_dec.opcode    = {4'h0, instr_word[13]};
      word_dec.lit13     = instr_word[12:0];
      word_dec.lit_is_13 = 1'b1;
      word_dec.pc_change = 1'b1;
    end else if (instr_word[15:13] == ifd_pkg::PFX_LIT) begin
      word_dec.cls    = ifd_pkg::IFD_CLS_LIT;
      word_dec.opcode = instr_word[12:8];
      if (ifd_pkg::LIT_VALID[instr_word[12:8]]) begin
        word_dec.pc_change  = ifd_pkg::LIT_PCCHG[instr_word[12:8]];
        word_dec.wr_working = !ifd_pkg::LIT_PCCHG[instr_word[12:8]];
      end else begin
        word_dec.illegal = 1'b1;
      end
    end else begin
      // Peripheral move: 5-bit peripheral field plus 8-bit file field
      word_dec.cls         = ifd_pkg::IFD_CLS_BYTE;
      word_dec.periph_addr = instr_word[12:8];
      word_dec.wr_file     = 1'b1;
    end
    if (word_dec.illegal) begin
      word_dec.valid      = 1'b0;
      word_dec.cls        = ifd_pkg::IFD_CLS_NONE;
      word_dec.wr_file    = 1'b0;
      word_dec.wr_working = 1'b0;
    end
    if (prot_now && !pc_internal && (word_dec.tbl_pm_rd || word_dec.tbl_pm_wr)) begin
      word_dec.tbl_blocked = 1'b1;
      word_dec.tbl_pm_rd   = 1'b0;
      word_dec.tbl_pm_wr   = 1'b0;
      word_dec.wr_file     = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Execution sequencer
  // ----------------------------------------------------------------------
  ifd_pkg::ifd_state_e state;
  ifd_pkg::ifd_state_e next_state;
  ifd_pkg::ifd_dec_s   next_dec;
  logic                next_nop_slot;
  logic                need_second;

  always_comb begin
    need_second   = dec.valid && (dec.pc_change ||
                    (dec.skip_test && cond_true) ||
                    dec.tbl_pm_rd || dec.tbl_pm_wr || dec.tbl_blocked);
    next_state    = state;
    next_dec      = dec;
    next_nop_slot = nop_slot;
    if (cycle_end) begin
      unique case (state)
        ifd_pkg::IFD_ST_EXEC: begin
          if (need_second) begin
            next_state    = ifd_pkg::IFD_ST_NOP;
            next_dec      = ifd_pkg::DEC_RESET;
            next_nop_slot = 1'b1;
          end else begin
            next_dec      = word_dec;
            next_nop_slot = 1'b0;
          end
        end
        ifd_pkg::IFD_ST_NOP: begin
          next_state    = ifd_pkg::IFD_ST_EXEC;
          next_dec      = word_dec;
          next_nop_slot = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state    <= ifd_pkg::IFD_ST_EXEC;
      dec      <= ifd_pkg::DEC_RESET;
      nop_slot <= 1'b0;
    end else begin
      state    <= next_state;
      dec      <= next_dec;
      nop_slot <= next_nop_slot;
    end
  end

endmodule : ifd_top
`default_nettype wire

// >>> ifd_top_note_unused.sv
// Holds no logic; all decode logic lives in the top file
`default_nettype none
`default_nettype wire

// >>> ifd_checker.sv
// Port assertions for the instruction format decoder
`timescale 1ns/1ps
`default_nettype none
module ifd_checker (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   srst,
  // Inputs
  input wire logic                   cond_true,
  input wire logic [2:0]             protection_mode_bits,
  // Outputs
  input wire logic [1:0]             osc_phase,
  input wire logic                   cycle_start,
  input wire logic                   nop_slot,
  input wire ifd_pkg::ifd_dec_s      dec,
  input wire logic                   code_protected,
  input wire logic                   verify_read_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_phase_step;
    1'b1 |=> osc_phase == $past(osc_phase) + 2'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase skipped");
  property p_start_phase;
    cycle_start |-> osc_phase == 2'h0;
  endproperty
  a_start_phase: assert property (p_start_phase) else $error("start off phase");
  property p_start_gap;
    cycle_start |=> !cycle_start [*3] ##1 cycle_start;
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("cycle not four");
  property p_dec_hold;
    !cycle_start && !$past(srst) |-> $stable(dec);
  endproperty
  a_dec_hold: assert property (p_dec_hold) else $error("dec moved");
  property p_two_cycle;
    cycle_start && (dec.pc_change || dec.tbl_pm_rd || dec.tbl_pm_wr || dec.tbl_blocked)
      |-> ##4 nop_slot;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("no second cycle");
  property p_skip_true;
    cycle_start && dec.skip_test ##3 cond_true |=> nop_slot;
  endproperty
  a_skip_true: assert property (p_skip_true) else $error("true test short");
  property p_one_cycle;
    cycle_start && !dec.skip_test && !dec.pc_change && !dec.tbl_pm_rd && !dec.tbl_pm_wr
      && !dec.tbl_blocked |-> ##4 !nop_slot;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("extra cycle");
  property p_nop_blank;
    nop_slot |-> !dec.valid && !dec.wr_file && !dec.wr_working;
  endproperty
  a_nop_blank: assert property (p_nop_blank) else $error("slot not idle");
  property p_prot_mode;
    !$past(srst) |-> code_protected == ($past(protection_mode_bits) == 3'h0)
      && verify_read_en != code_protected;
  endproperty
  a_prot_mode: assert property (p_prot_mode) else $error("protect wrong");
endmodule : ifd_checker
`default_nettype wire

// >>> ifd_fetch_model.sv
// Program memory fetch path feeding the decoder
`timescale 1ns/1ps
`default_nettype none
module ifd_fetch_model (
  // Staged fetch
  input wire logic [15:0]  word_stage,
  input wire logic [15:0]  pc_stage,
  input wire logic [1:0]   osc_phase,
  // Decoder fetch side
  output logic [15:0]      instr_word,
  output logic [15:0]      instr_pc
);
  // Outside the sampling phase the bus carries garbage, not the last word
  assign instr_word = osc_phase == 2'h3 ? word_stage : ~word_stage;
  assign instr_pc   = osc_phase == 2'h3 ? pc_stage : ~pc_stage;
endmodule : ifd_fetch_model
`default_nettype wire

// >>> ifd_top_bench.sv
// Self-checking bench for the instruction format decoder
`timescale 1ns/1ps
`default_nettype none
module ifd_top_bench;
  logic clk, srst, cond_true, cond_next, pend, chk_cls, chk_wr;
  logic [15:0] word_stage, pc_stage, int_mem_last, w;
  logic [2:0] protection_mode_bits;
  wire logic [15:0] instr_word, instr_pc;
  wire logic [1:0] osc_phase;
  wire logic cycle_start, nop_slot, code_protected, verify_read_en;
  wire ifd_pkg::ifd_dec_s dec;
  ifd_pkg::ifd_dec_s e;
  int errors, tests_run;
  ifd_fetch_model fetch (.word_stage(word_stage), .pc_stage(pc_stage), .osc_phase(osc_phase),
    .instr_word(instr_word), .instr_pc(instr_pc));
  ifd_top dut (.clk(clk), .srst(srst), .instr_word(instr_word), .instr_pc(instr_pc),
    .cond_true(cond_true), .protection_mode_bits(protection_mode_bits),
    .int_mem_last(int_mem_last), .osc_phase(osc_phase), .cycle_start(cycle_start),
    .nop_slot(nop_slot), .dec(dec), .code_protected(code_protected),
    .verify_read_en(verify_read_en));
  task automatic report_and_stop();
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Reference decode of one word
  function automatic ifd_pkg::ifd_dec_s model(input logic [15:0] x);
    ifd_pkg::ifd_dec_s m;
    logic [4:0] op;
    logic pm;
    m = ifd_pkg::DEC_RESET;
    op = x[13:9];
    chk_cls = 1'b1;
    chk_wr = 1'b1;
    m.valid = 1'b1;
    m.file_addr = x[7:0];
    if (x[15:14] == 2'h0) begin
      m.cls = ifd_pkg::IFD_CLS_BYTE;
      m.opcode = op;
      m.valid = op > 5'h1;
      m.wr_file = op < 5'h4 || x[8];
      m.wr_working = !x[8];
      m.skip_test = op[4:2] == 3'h5;
      chk_wr = op < 5'h14;
      chk_cls = op < 5'h18;
      m.tbl_op = op > 5'h17;
      m.tbl_inc = x[8];
      m.tbl_hi = op[0];
      pm = m.tbl_op && !op[2];
      m.tbl_blocked = pm && protection_mode_bits == 3'h0 && pc_stage > int_mem_last;
      m.tbl_pm_rd = pm && !m.tbl_blocked && !op[1];
      m.tbl_pm_wr = pm && !m.tbl_blocked && op[1];
    end else if (x[15:14] == 2'h2) begin
      m.cls = ifd_pkg::IFD_CLS_BIT;
      m.valid = x[13:11] < 3'h5;
      m.bit_num = x[10:8];
      m.opcode = {2'h0, x[13:11]};
      m.skip_test = x[13:12] == 2'h1;
      m.wr_file = !m.skip_test;
    end else if (x[15:13] == 3'h2) begin
      m.cls = ifd_pkg::IFD_CLS_LIT;
      m.valid = x[12:8] < 5'h14;
      m.opcode = x[12:8];
      m.pc_change = x[12:8] < 5'h4;
      m.wr_working = !m.pc_change;
      m.lit8 = x[7:0];
    end else if (x[15]) begin
      m.cls = ifd_pkg::IFD_CLS_LIT;
      m.opcode = {4'h0, x[13]};
      m.lit_is_13 = 1'b1;
      m.lit13 = x[12:0];
      m.pc_change = 1'b1;
    end else begin
      m.cls = ifd_pkg::IFD_CLS_BYTE;
      m.periph_addr = x[12:8];
      m.wr_file = 1'b1;
    end
    if (!m.valid) begin
      m = '{illegal: 1'b1, cls: ifd_pkg::IFD_CLS_NONE, default: '0};
      chk_cls = 1'b1;
      chk_wr = 1'b1;
    end
    return m;
  endfunction : model
  task automatic wait_ph3();
    for (int n = 0; osc_phase !== 2'h3; n++) begin
      if (n > 8) begin
        errors++;
        report_and_stop();
      end
      @(posedge clk);
      #1;
    end
  endtask : wait_ph3
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    errors = 0;
    tests_run = 0;
    srst = 1'b1;
    cond_true = 1'b0;
    cond_next = 1'b0;
    pend = 1'b0;
    word_stage = '0;
    pc_stage = '0;
    int_mem_last = 16'h3fff;
    protection_mode_bits = 3'h0;
    void'($urandom(38851));
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    for (int i = 0; i < 400; i++) begin
      wait_ph3();
      cond_true = cond_next;
      word_stage = 16'($urandom);
      pc_stage = 16'($urandom);
      w = word_stage;
      if (!pend) e = model(w);
      @(posedge clk);
      #1;
      check("start", {cycle_start, osc_phase}, 3'h4);
      check("nop", nop_slot, pend);
      if (pend) check("slot", dec.valid, 1'b0);
      else begin
        check("valid", {dec.valid, dec.illegal}, {e.valid, e.illegal});
        if (chk_cls) check("class", dec.cls, e.cls);
        if (chk_wr) begin
          check("dest", {dec.wr_working, dec.wr_file}, {e.wr_working, e.wr_file});
        end
        if (e.valid) begin
          check("flow", {dec.skip_test, dec.pc_change}, {e.skip_test, e.pc_change});
          check("pm rd", dec.tbl_pm_rd, e.tbl_pm_rd);
          check("pm wr", dec.tbl_pm_wr, e.tbl_pm_wr);
          check("guard", dec.tbl_blocked, e.tbl_blocked);
          check("opcode", dec.opcode, e.opcode);
        end
        if (e.cls inside {ifd_pkg::IFD_CLS_BYTE, ifd_pkg::IFD_CLS_BIT}) begin
          check("file", dec.file_addr, e.file_addr);
        end
        if (e.cls == ifd_pkg::IFD_CLS_BIT) check("bit", dec.bit_num, e.bit_num);
        if (w[15:13] == 3'h2 && e.valid) check("lit8", dec.lit8, e.lit8);
        if (e.lit_is_13) check("lit13", {dec.lit_is_13, dec.lit13}, {1'b1, e.lit13});
        if (w[15:13] == 3'h3) check("periph", dec.periph_addr, e.periph_addr);
        if (e.tbl_op) begin
          check("tbl inc", {dec.tbl_op, dec.tbl_inc}, {1'b1, e.tbl_inc});
          check("tbl hi", dec.tbl_hi, e.tbl_hi);
        end
        cond_next = 1'($urandom);
        pend = e.pc_change | e.tbl_pm_rd | e.tbl_pm_wr | e.tbl_blocked | (e.skip_test & cond_next);
      end
      if (pend && dec.valid !== 1'b1) pend = 1'b0;
      check("prot", {code_protected, verify_read_en}, {protection_mode_bits == 3'h0,
        protection_mode_bits != 3'h0});
      protection_mode_bits = 3'(i / 25);
    end
    report_and_stop();
  end
endmodule : ifd_top_bench
bind ifd_top ifd_checker chk (.clk(clk), .srst(srst), .cond_true(cond_true),
  .protection_mode_bits(protection_mode_bits), .osc_phase(osc_phase),
  .cycle_start(cycle_start), .nop_slot(nop_slot), .dec(dec),
  .code_protected(code_protected), .verify_read_en(verify_read_en));
`default_nettype wire
